// >>> ics_pkg.sv
// Purpose: constants and types for the slave clock stretch block
// Assumes: apb data 32 bits, one aligned word per register
// Notes: offsets and bit positions are used by design and bench
// ****************************************************************
// package
// ****************************************************************
package ics_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_BUF = 8'h0c;
  // control register fields
  localparam int CTRL_RELEASE = 0;
  localparam int CTRL_STRETCH_EN = 1;
  localparam int CTRL_ADDR_HOLD = 2;
  localparam int CTRL_DATA_HOLD = 3;
  localparam int CTRL_TEN_BIT = 4;
  localparam int CTRL_NACK = 5;
  localparam logic [5:0] CTRL_RESET = 6'h01;
  // status register fields
  localparam int STAT_BUF_FULL = 0;
  localparam int STAT_ADDR_UPDATE = 1;
  localparam int STAT_READ_REQ = 2;
  localparam int STAT_SCL_HELD = 3;
  localparam int STAT_ADDRESSED = 4;
  // reset values
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] BUF_RESET = 8'h00;
  // bit counter marks
  localparam logic [3:0] CNT_PRE = 4'hf;
  localparam logic [3:0] CNT_LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  // protocol states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR2,
    ST_RX,
    ST_TX
  } ics_state_t;
endpackage

// >>> ics_stretch.sv
// Purpose: slave side clock stretching with apb registers
// Assumes: scl_link_clk_in and scl_in both tied to the scl wire
// Notes: protocol tracked on clock_in from synchronised pins
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module ics_stretch
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic scl_link_clk_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out
);
  import ics_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0] link_shift;
  logic scl_meta;
  logic scl_sync;
  logic scl_prev;
  logic sda_meta;
  logic sda_sync;
  logic sda_prev;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic ack_done;
  ics_state_t state;
  logic [3:0] bit_cnt;
  logic matched;
  logic read_req;
  logic [5:0] ctrl;
  logic [7:0] slave_address_reg;
  logic [7:0] shift_buffer_reg;
  logic [7:0] tx_byte;
  logic buffer_full_flag;
  logic address_update_flag;
  logic hw_clear;
  logic ua_set;
  logic stretch_cond;
  logic scl_hold;
  logic next_sda_oe;
  logic apb_setup;
  logic apb_write;
  logic apb_read;
  logic addr_ok;
  logic hi_match;
  logic lo_match;

  // ****************************************************************
  // link domain
  // ****************************************************************
  // data bits sampled on each rising scl edge
  always_ff @(posedge scl_link_clk_in)
  begin
    link_shift <= {link_shift[6:0], sda_in};
  end

  // ****************************************************************
  // pin synchronisers and line events
  // ****************************************************************
  // two stages before any clock_in logic reads scl or sda
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  // edges, start and stop from the synchronised lines
  assign scl_fall = scl_prev & ~scl_sync;
  assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_seen = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign byte_done = scl_fall && (bit_cnt == CNT_LAST_BIT) && (state != ST_IDLE);
  assign ack_done = scl_fall && (bit_cnt == CNT_ACK) && (state != ST_IDLE);
  // address compares against the word taken from the link shifter
  assign hi_match = (link_shift[7:1] == slave_address_reg[7:1]);
  assign lo_match = (link_shift == slave_address_reg);

  // ****************************************************************
  // protocol tracking
  // ****************************************************************
  // bit counter: preamble mark after start, 8 marks the ack slot
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      bit_cnt <= CNT_PRE;
    else if (start_seen)
      bit_cnt <= CNT_PRE;
    else if (scl_fall && bit_cnt == CNT_ACK)
      bit_cnt <= 4'h0;
    else if (scl_fall)
      bit_cnt <= bit_cnt + 4'h1;
  end

  // address phase, direction and transfer state
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      state <= ST_IDLE;
      matched <= 1'b0;
      read_req <= 1'b0;
    end
    else if (start_seen)
    begin
      state <= ST_ADDR;
      matched <= 1'b0;
    end
    else if (stop_seen)
    begin
      state <= ST_IDLE;
      matched <= 1'b0;
    end
    else if (byte_done && state == ST_ADDR)
    begin
      matched <= hi_match;
      if (hi_match)
        read_req <= link_shift[0];
    end
    else if (byte_done && state == ST_ADDR2)
      matched <= lo_match;
    else if (ack_done)
    begin
      case (state)
        ST_ADDR:
          if (!matched)
            state <= ST_IDLE;
          else if (read_req)
            state <= ST_TX;
          else if (ctrl[CTRL_TEN_BIT])
            state <= ST_ADDR2;
          else
            state <= ST_RX;
        ST_ADDR2:
          state <= matched ? ST_RX : ST_IDLE;
        ST_RX:
          state <= ST_RX;
        ST_TX:
          state <= link_shift[0] ? ST_IDLE : ST_TX; // master nack frees sda for the stop
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // hardware stretch requests
  // ****************************************************************
  // events that clear the release bit; buffer full never enters here
  always_comb
  begin
    hw_clear = 1'b0;
    if (byte_done && state == ST_ADDR && hi_match && ctrl[CTRL_ADDR_HOLD])
      hw_clear = 1'b1;
    if (byte_done && state == ST_ADDR2 && lo_match && ctrl[CTRL_ADDR_HOLD])
      hw_clear = 1'b1;
    if (byte_done && state == ST_RX && ctrl[CTRL_DATA_HOLD])
      hw_clear = 1'b1;
    if (ack_done && state == ST_ADDR && matched && read_req)
      hw_clear = 1'b1;
    if (ack_done && matched && ctrl[CTRL_STRETCH_EN])
      hw_clear = 1'b1;
  end

  // ten bit address bytes that match in a write ask software for an update
  assign ua_set = ctrl[CTRL_TEN_BIT] && byte_done &&
                  ((state == ST_ADDR && hi_match && !link_shift[0]) ||
                   (state == ST_ADDR2 && lo_match));

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // zero wait state; unmapped offsets answer with an error
  assign apb_setup = psel_in & ~penable_in;
  assign apb_write = psel_in & penable_in & pwrite_in & addr_ok;
  assign apb_read = psel_in & penable_in & ~pwrite_in & addr_ok;
  assign addr_ok = (paddr_in == OFS_CTRL) || (paddr_in == OFS_STATUS) ||
                   (paddr_in == OFS_ADDR) || (paddr_in == OFS_BUF);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_ok;

  // read data captured in the setup cycle, stable in the access cycle
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      prdata_out <= 32'h00000000;
    else if (apb_setup)
    begin
      case (paddr_in)
        OFS_CTRL:
          prdata_out <= {26'h0, ctrl};
        OFS_STATUS:
          prdata_out <= {27'h0, matched, scl_hold, read_req,
                         address_update_flag, buffer_full_flag};
        OFS_ADDR:
          prdata_out <= {24'h000000, slave_address_reg};
        OFS_BUF:
          prdata_out <= {24'h000000, shift_buffer_reg};
        default:
          prdata_out <= 32'h00000000;
      endcase
    end
  end

  // control bits; a hardware clear beats a software set in one cycle
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      ctrl <= CTRL_RESET;
    else
    begin
      if (apb_write && paddr_in == OFS_CTRL)
        ctrl <= pwdata_in[5:0];
      if (hw_clear)
        ctrl[CTRL_RELEASE] <= 1'b0;
    end
  end

  // slave address register
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      slave_address_reg <= ADDR_RESET;
    else if (apb_write && paddr_in == OFS_ADDR)
      slave_address_reg <= pwdata_in[7:0];
  end

  // address update flag: set wins over the clearing address write
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      address_update_flag <= 1'b0;
    else if (ua_set)
      address_update_flag <= 1'b1;
    else if (apb_write && paddr_in == OFS_ADDR)
      address_update_flag <= 1'b0;
  end

  // receive buffer and full flag; a new byte wins over the read
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      shift_buffer_reg <= BUF_RESET;
      buffer_full_flag <= 1'b0;
    end
    else if (byte_done && state == ST_RX)
    begin
      shift_buffer_reg <= link_shift;
      buffer_full_flag <= 1'b1;
    end
    else if (apb_read && paddr_in == OFS_BUF)
      buffer_full_flag <= 1'b0;
  end

  // transmit byte loaded by software writes to the buffer offset
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      tx_byte <= BUF_RESET;
    else if (apb_write && paddr_in == OFS_BUF)
      tx_byte <= pwdata_in[7:0];
  end

  // ****************************************************************
  // scl stretch and sda drive
  // ****************************************************************
  // update stretch does not touch the release bit
  assign stretch_cond = ~ctrl[CTRL_RELEASE] | address_update_flag;

  // hold begins only on a low line and lasts while the cause stays
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      scl_hold <= 1'b0;
    else
      scl_hold <= stretch_cond & (scl_hold | ~scl_sync);
  end

  // open drain pull down while held
  assign scl_out = 1'b0;
  assign scl_oe_out = scl_hold;

  // ack slot and transmit bits
  always_comb
  begin
    next_sda_oe = 1'b0;
    case (state)
      ST_ADDR, ST_ADDR2:
        next_sda_oe = (bit_cnt == CNT_ACK) && matched && !ctrl[CTRL_NACK];
      ST_RX:
        next_sda_oe = (bit_cnt == CNT_ACK) && !ctrl[CTRL_NACK];
      ST_TX:
        next_sda_oe = (bit_cnt < CNT_ACK) && !tx_byte[3'h7 - bit_cnt[2:0]];
      default:
        next_sda_oe = 1'b0;
    endcase
  end

  // sda drive from a flip-flop
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      sda_oe_out <= 1'b0;
    else
      sda_oe_out <= next_sda_oe;
  end

  assign sda_out = 1'b0;

endmodule

`default_nettype wire

// >>> ics_stretch_properties.sv
// Purpose: port checks for the clock stretch block
// Assumes: one clock domain, synchronous reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module ics_stretch_properties
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic scl_link_clk_in,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out
);
  import ics_pkg::*;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);
  // completing access and completing write
  logic acc;
  logic wr;
  assign acc = psel_in && penable_in;
  assign wr = acc && pwrite_in;
  property p_hold_low;
    $rose(scl_oe_out) |-> !$past(scl_in) && !$past(scl_in, 2);
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("hold began on a high scl");
  property p_pull_only;
    scl_oe_out || sda_oe_out |-> !scl_out && !sda_out;
  endproperty
  a_pull_only: assert property (p_pull_only)
    else $error("pin driven high");
  property p_hold_stays;
    scl_oe_out && !wr && !$past(wr) |=> scl_oe_out;
  endproperty
  a_hold_stays: assert property (p_hold_stays)
    else $error("hold dropped with no write");
  property p_release;
    scl_oe_out && wr && paddr_in == OFS_CTRL && pwdata_in[CTRL_RELEASE] |-> ##[1:2] !scl_oe_out;
  endproperty
  a_release: assert property (p_release)
    else $error("release bit did not free scl");
  property p_addr_free;
    scl_oe_out && wr && paddr_in == OFS_ADDR |-> ##[1:2] !scl_oe_out;
  endproperty
  a_addr_free: assert property (p_addr_free)
    else $error("address write did not free scl");
  property p_ready;
    acc |-> pready_out;
  endproperty
  a_ready: assert property (p_ready)
    else $error("no ready in access");
  property p_unmapped;
    acc && paddr_in > OFS_BUF |-> pslverr_out && (pwrite_in || prdata_out == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_mapped;
    acc && paddr_in <= OFS_BUF && paddr_in[1:0] == 2'h0 |-> !pslverr_out;
  endproperty
  a_mapped: assert property (p_mapped)
    else $error("mapped access refused");
endmodule
bind ics_stretch ics_stretch_properties u_props (.clock_in(clock_in), .reset_in(reset_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .scl_link_clk_in(scl_link_clk_in), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out));
`default_nettype wire

// >>> ics_i2c_master.sv
// Purpose: behavioural bus master on the serial link
// Assumes: open drain wires with pull-ups
// Notes: each scl phase is four 64 ns link ticks
`timescale 1ns/1ps
`default_nettype none
// ****
// master model
// ****
module ics_i2c_master
(
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_dn_out,
  output logic sda_dn_out
);
  logic [1:0] acks;
  // both wires released, clock still outside frames
  initial
  begin
    scl_dn_out = 1'b0;
    sda_dn_out = 1'b0;
  end
  // one scl phase
  task automatic half();
    repeat (4) #64;
  endtask
  // one clock pulse, waiting out any slave stretch
  task automatic pulse(output logic s);
    half();
    scl_dn_out = 1'b0;
    wait (scl_in);
    half();
    s = sda_in;
    scl_dn_out = 1'b1;
    #64;
  endtask
  // eight bits msb first, all ones to receive
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
    begin
      sda_dn_out = !d[i];
      pulse(q[i]);
    end
    sda_dn_out = 1'b0;
  endtask
  // start, two bytes with their ack slots, stop
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic rd,
    output logic [7:0] q);
    logic s;
    sda_dn_out = 1'b1;
    half();
    scl_dn_out = 1'b1;
    #64;
    byte_io(a, q);
    pulse(s);
    acks[1] = !s;
    byte_io(rd ? 8'hff : d, q);
    pulse(s);
    acks[0] = !s;
    sda_dn_out = 1'b1;
    half();
    scl_dn_out = 1'b0;
    wait (scl_in);
    half();
    sda_dn_out = 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// >>> tb_ics_stretch.sv
// Purpose: self-checking bench for the clock stretch block
// Assumes: pull-ups on both wires, master model on the link
// Notes: random bytes come from a bench lfsr
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
// ****
// bench
// ****
module tb_ics_stretch;
  import ics_pkg::*;
  logic clock_in, reset_in, psel, pen, pwr, err, scl_oe, sda_oe, m_scl, m_sda;
  logic pready, pslverr;
  logic [7:0] paddr, q, b;
  logic [31:0] pwdata, prdata, r, seed;
  int n_fail, comparisons;
  int en_t[4] = '{CTRL_DATA_HOLD, CTRL_ADDR_HOLD, CTRL_RELEASE, CTRL_STRETCH_EN};
  wire logic scl = !(scl_oe || m_scl);
  wire logic sda = !(sda_oe || m_sda);
  ics_stretch u_dut (.clock_in(clock_in), .reset_in(reset_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .scl_link_clk_in(scl), .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe));
  ics_i2c_master u_mst (.scl_in(scl), .sda_in(sda), .scl_dn_out(m_scl), .sda_dn_out(m_sda));
  // random source and control word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ctl(input int e);
    return 32'h1 | (32'h1 << e);
  endfunction
  // system clock
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = !clock_in;
  end
  // one apb transfer, result in r and err
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    pen <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // wait for a stretch, check the flags, then free the bus
  task automatic serve(input logic rel, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    while (scl_oe !== 1'b1 && n < 400)
    begin
      @(posedge clock_in);
      n++;
    end
    apb(OFS_CTRL, 1'b0, 32'h0);
    `CHK(r[CTRL_RELEASE], rel)
    apb(OFS_STATUS, 1'b0, 32'h0);
    `CHK(r[STAT_ADDR_UPDATE], rel)
    apb(a, 1'b1, d);
    repeat (3) @(posedge clock_in);
  endtask
  // counts and verdict
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // reset, registers, then the stretch scenarios
  initial
  begin
    reset_in = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'hc5ae;
    n_fail = 0;
    comparisons = 0;
    repeat (3) @(posedge clock_in);
    reset_in <= 1'b0;
    apb(OFS_CTRL, 1'b0, 32'h0);
    `CHK(r, {26'h0, CTRL_RESET})
    apb(8'h10, 1'b0, 32'h0);
    `CHK({err, r}, {1'b1, 32'h0})
    seed = lfsr(seed);
    apb(OFS_ADDR, 1'b1, seed);
    apb(OFS_ADDR, 1'b0, 32'h0);
    `CHK(r, {24'h0, seed[7:0]})
    $display("test 0 done");
    apb(OFS_ADDR, 1'b1, 32'ha0);
    for (int m = 0; m < 4; m++)
    begin
      seed = lfsr(seed);
      b = seed[7:0];
      apb(OFS_CTRL, 1'b1, ctl(en_t[m]));
      apb(OFS_BUF, 1'b1, {24'h0, b});
      fork
        u_mst.frame({7'h50, m == 2}, b, m == 2, q);
        repeat (1 + (m == 3)) serve(1'b0, OFS_CTRL, ctl(en_t[m]));
      join
      `CHK(u_mst.acks, (m == 2) ? 2'h2 : 2'h3)
      apb(OFS_BUF, 1'b0, 32'h0);
      `CHK((m == 2) ? q : r[7:0], b)
      $display("test %0d done", m + 1);
    end
    apb(OFS_ADDR, 1'b1, 32'hf0);
    apb(OFS_CTRL, 1'b1, ctl(CTRL_TEN_BIT));
    fork
      u_mst.frame(8'hf0, 8'h5a, 1'b0, q);
      begin
        serve(1'b1, OFS_ADDR, 32'h5a);
        serve(1'b1, OFS_ADDR, 32'hf0);
      end
    join
    `CHK(u_mst.acks, 2'h3)
    $display("test 5 done");
    report_and_stop();
  end
  // watchdog against a hung bus
  initial
  begin
    repeat (40000) @(posedge clock_in);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
